/* iscr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iscr_core_model
(
    input  wire logic       pclk,
    input  wire logic       core_irq,
    input  wire logic [1:0] delay,
    output logic            service_entry
);
    logic [2:0] cnt = 3'h0;
    initial service_entry = 1'b0;
    // One entry pulse per request, after a chosen delay
    always @(posedge pclk)
    begin
        cnt <= !core_irq ? 3'h0 : cnt + 3'(cnt != 3'h7);
        service_entry <= core_irq && cnt == {1'b0, delay};
    end
endmodule
`default_nettype wire

/* iscr_pkg.sv */
package iscr_pkg;

    // Register indices (word offsets); byte address is four times the index
    localparam logic [7:0]  IDX_CONTROL_STATUS  = 8'h12;
    localparam logic [7:0]  IDX_PENDING_LOWER   = 8'h10;
    localparam logic [7:0]  IDX_PENDING_MIDDLE  = 8'h11;
    localparam logic [7:0]  IDX_PENDING_UPPER   = 8'h13;
    localparam logic [9:0]  ADDR_CONTROL_STATUS = {IDX_CONTROL_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_PENDING_LOWER  = {IDX_PENDING_LOWER, 2'b00};
    localparam logic [9:0]  ADDR_PENDING_MIDDLE = {IDX_PENDING_MIDDLE, 2'b00};
    localparam logic [9:0]  ADDR_PENDING_UPPER  = {IDX_PENDING_UPPER, 2'b00};

    // Vector numbers
    localparam int          VEC_FIRST           = 2;
    localparam int          VEC_LAST            = 45;
    localparam int          VEC_COUNT           = VEC_LAST - VEC_FIRST + 1;
    localparam int          LOWER_BITS          = 15;
    localparam int          MIDDLE_BITS         = 16;
    localparam int          UPPER_BITS          = 13;

    // Control/status field positions
    localparam int          POS_LINE            = 15;
    localparam int          POS_LEVEL_HI        = 14;
    localparam int          POS_LEVEL_LO        = 13;
    localparam int          POS_VEC_HI          = 12;
    localparam int          POS_VEC_LO          = 6;
    localparam int          POS_GLOBAL_BLOCK    = 5;
    localparam logic [15:0] CONTROL_RESET       = 16'h001c;
    localparam logic [15:0] CONTROL_FIXED_ONES  = 16'h001c;
    localparam logic [15:0] UPPER_PAD_ONES      = 16'he000;
    localparam logic [15:0] LOWER_PAD_ONES      = 16'h0001;

    // Nesting level codes
    localparam logic [1:0]  LEVEL_ANY           = 2'h0;
    localparam logic [1:0]  LEVEL_AFTER_0       = 2'h1;
    localparam logic [1:0]  LEVEL_AFTER_1       = 2'h2;
    localparam logic [1:0]  LEVEL_ONLY_3        = 2'h3;

    // Reset vector hold after reset release, in clock edges
    localparam int          RESET_HOLD_EDGES    = 2;
    localparam logic [1:0]  RESET_HOLD_LAST     = 2'h1;

    typedef enum logic [2:0]
    {
        RV_HOLD    = 3'b001,
        RV_RELEASE = 3'b010,
        RV_RUN     = 3'b100
    } iscr_rv_state_type;

endpackage

/* iscr_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module iscr_properties
    import iscr_pkg::*;
#(
    parameter int VEC_BUS_WIDTH = 21
)
(
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [9:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [3:0]               pstrb,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    input wire logic [VEC_COUNT-1:0]     irq_pending,
    input wire logic                     irq_request,
    input wire logic [1:0]               irq_level,
    input wire logic                     service_entry,
    input wire logic                     core_reset_n,
    input wire logic [VEC_BUS_WIDTH-1:0] reset_vector,
    input wire logic [VEC_BUS_WIDTH-1:0] irq_vector_addr,
    input wire logic                     core_irq,
    input wire logic [1:0]               nested_level_required,
    input wire logic [VEC_BUS_WIDTH-1:0] vector_bus,
    input wire logic                     reset_vector_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic blk;
    logic rd;
    assign rd = psel && !penable && !pwrite;
    // Shadow of the global block bit
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            blk <= 1'b0;
        else if (psel && penable && pwrite && pstrb[0] && paddr == ADDR_CONTROL_STATUS)
            blk <= pwdata[POS_GLOBAL_BLOCK];
    a_block_masks: assert property (blk |=> !core_irq) else $error("irq while blocked");
    a_irq_drives: assert property (
        irq_request && !blk && !reset_vector_active |=> core_irq) else $error("irq missing");
    a_irq_drops: assert property (!irq_request |=> !core_irq) else $error("irq stuck");
    a_level_entry: assert property (
        service_entry |=> nested_level_required == $past(irq_level)) else $error("level not taken");
    a_level_holds: assert property (
        !service_entry |=> $stable(nested_level_required)) else $error("level moved");
    a_vec_reset: assert property (
        !core_reset_n |=> vector_bus == $past(reset_vector)) else $error("no reset vector");
    a_vec_release: assert property (
        $rose(core_reset_n) |=> vector_bus == $past(reset_vector)
        ##1 vector_bus == $past(irq_vector_addr)) else $error("bad release");
    a_pad_bits: assert property (
        rd && paddr == ADDR_CONTROL_STATUS |=>
        prdata[4:0] == 5'h1c && prdata[31:16] == 16'h0000) else $error("pad bits");
    a_upper_flags: assert property (
        rd && paddr == ADDR_PENDING_UPPER |=>
        prdata[15:0] == {3'b111, ~$past(irq_pending[43:31])}) else $error("upper");
    c_entry: cover property (service_entry);
    c_release: cover property ($rose(core_reset_n));
    c_error: cover property (pslverr);
endmodule
bind iscr_top iscr_properties #(.VEC_BUS_WIDTH(VEC_BUS_WIDTH)) u_props (.*);
`default_nettype wire

/* iscr_top.sv */
// Function
// - Pending flags for vectors 2..45 in three registers; third holds 33..45.
// - Pending flags read zero when pending, one when idle.
// - Control bit 15 reads one while an interrupt goes to the core.
// - Bits 14-13 encode current level and minimum level that may nest.
// - Nesting field updates only on entry into a new service routine.
// - Bits 12-6 capture last taken vector number on service entry.
// - For a fast interrupt the field holds low jump-address bits instead.
// - Writable bit 5 blocks all interrupts toward the core; reset zero.
// - Bits 4-2 read one, bits 1-0 read zero; writes ignored.
// - Drive reset vector while core reset asserted, until second edge after release.
// - After reset the control register defaults with bit 5 clear, so interrupts toward the core are not blocked.
`timescale 1ns/1ps
`default_nettype none

module iscr_top
    import iscr_pkg::*;
#(
    parameter int VEC_BUS_WIDTH = 21
)
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [9:0]               paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [VEC_COUNT-1:0]     irq_pending,
    input  wire logic                     irq_request,
    input  wire logic [1:0]               irq_level,
    input  wire logic [6:0]               irq_vector,
    input  wire logic                     irq_fast,
    input  wire logic [6:0]               fast_addr_low,
    input  wire logic                     service_entry,
    input  wire logic                     core_reset_n,
    input  wire logic [VEC_BUS_WIDTH-1:0] reset_vector,
    input  wire logic [VEC_BUS_WIDTH-1:0] irq_vector_addr,
    output logic                          core_irq,
    output logic      [1:0]               nested_level_required,
    output logic      [VEC_BUS_WIDTH-1:0] vector_bus,
    output logic                          reset_vector_active
);

    // Field widths derived from the layout
    localparam int VEC_FIELD_BITS = POS_VEC_HI - POS_VEC_LO + 1;
    localparam int LEVEL_BITS     = POS_LEVEL_HI - POS_LEVEL_LO + 1;
    localparam int UPPER_LSB      = LOWER_BITS + MIDDLE_BITS;

    logic                     global_block;
    logic                     next_global_block;
    logic [6:0]               last_vector;
    logic [6:0]               next_last_vector;
    logic [1:0]               next_nested_level;
    logic [15:0]              control_word;
    logic [15:0]              lower_word;
    logic [15:0]              middle_word;
    logic [15:0]              upper_word;
    logic [15:0]              read_word;
    logic [31:0]              next_prdata;
    logic [VEC_COUNT-1:0]     pending_n;
    logic                     access_phase;
    logic                     setup_read;
    logic                     bus_write;
    logic                     control_write;
    logic                     sel_control;
    logic                     sel_lower;
    logic                     sel_middle;
    logic                     sel_upper;
    logic                     addr_hit;
    logic                     next_core_irq;
    logic                     core_run;
    iscr_rv_state_type        rv_state;
    iscr_rv_state_type        next_rv_state;
    logic [VEC_BUS_WIDTH-1:0] next_vector_bus;

    // Refuse parameter values the logic cannot serve
    if (VEC_BUS_WIDTH < VEC_FIELD_BITS)
    begin
        $error("VEC_BUS_WIDTH below vector field width");
    end

    if (LOWER_BITS + MIDDLE_BITS + UPPER_BITS != VEC_COUNT)
    begin
        $error("Pending flag split does not cover every vector");
    end

    if (VEC_FIELD_BITS != $bits(irq_vector))
    begin
        $error("Vector field width mismatch");
    end

    if (LEVEL_BITS != $bits(irq_level))
    begin
        $error("Level field width mismatch");
    end

    if (LOWER_BITS + 1 > $bits(lower_word))
    begin
        $error("Lower pending word overflow");
    end

    if (MIDDLE_BITS > $bits(middle_word))
    begin
        $error("Middle pending word overflow");
    end

    if (UPPER_BITS > $bits(upper_word))
    begin
        $error("Upper pending word overflow");
    end

    // APB phases; every access finishes in its first access cycle
    assign access_phase  = psel && penable;
    assign setup_read    = psel && !penable && !pwrite;
    assign bus_write     = access_phase && pwrite;
    assign control_write = bus_write && sel_control && pstrb[0];
    assign pready        = 1'b1;
    assign pslverr       = access_phase && !addr_hit;

    // Address decode
    always_comb
    begin
        sel_control = 1'b0;
        sel_lower   = 1'b0;
        sel_middle  = 1'b0;
        sel_upper   = 1'b0;
        case (paddr)
            ADDR_CONTROL_STATUS:
                sel_control = 1'b1;
            ADDR_PENDING_LOWER:
                sel_lower = 1'b1;
            ADDR_PENDING_MIDDLE:
                sel_middle = 1'b1;
            ADDR_PENDING_UPPER:
                sel_upper = 1'b1;
            default:
                sel_control = 1'b0;
        endcase
    end

    assign addr_hit = sel_control || sel_lower || sel_middle || sel_upper;

    // Global block bit, the only writable control field
    always_comb
    begin
        next_global_block = global_block;
        if (control_write)
            next_global_block = pwdata[POS_GLOBAL_BLOCK];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            global_block <= CONTROL_RESET[POS_GLOBAL_BLOCK];
        else
            global_block <= next_global_block;
    end

    // Request line to the core, held low during the reset vector handshake
    assign core_run = (rv_state == RV_RUN);

    always_comb
    begin
        next_core_irq = irq_request && !global_block;
        if (!core_run)
            next_core_irq = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_irq <= 1'b0;
        else
            core_irq <= next_core_irq;
    end

    // Nesting level moves only on entry into a new service routine
    always_comb
    begin
        next_nested_level = nested_level_required;
        if (service_entry)
            next_nested_level = irq_level;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nested_level_required <= LEVEL_ANY;
        else
            nested_level_required <= next_nested_level;
    end

    // Vector field; a fast interrupt leaves its low jump-address bits
    always_comb
    begin
        next_last_vector = last_vector;
        if (service_entry)
        begin
            if (irq_fast)
                next_last_vector = fast_addr_low;
            else
                next_last_vector = irq_vector;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_vector <= '0;
        else
            last_vector <= next_last_vector;
    end

    // Reset vector handshake
    always_comb
    begin
        next_rv_state = rv_state;
        case (rv_state)
            RV_HOLD:
                next_rv_state = RV_RELEASE;
            RV_RELEASE:
                next_rv_state = RV_RUN;
            RV_RUN:
                next_rv_state = RV_RUN;
            default:
                next_rv_state = RV_HOLD;
        endcase
        if (!core_reset_n)
            next_rv_state = RV_HOLD;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rv_state <= RV_HOLD;
        else
            rv_state <= next_rv_state;
    end

    always_comb
    begin
        reset_vector_active = 1'b0;
        if (!core_reset_n || !core_run)
            reset_vector_active = 1'b1;
    end

    always_comb
    begin
        if (!core_reset_n || next_rv_state != RV_RUN)
            next_vector_bus = reset_vector;
        else
            next_vector_bus = irq_vector_addr;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vector_bus <= '0;
        else
            vector_bus <= next_vector_bus;
    end

    // Register read views
    always_comb
    begin
        control_word                              = CONTROL_FIXED_ONES;
        control_word[POS_LINE]                    = core_irq;
        control_word[POS_LEVEL_HI:POS_LEVEL_LO]   = nested_level_required;
        control_word[POS_VEC_HI:POS_VEC_LO]       = last_vector;
        control_word[POS_GLOBAL_BLOCK]            = global_block;
    end

    // Per-vector flags, active low
    for (genvar i = 0; i < VEC_COUNT; i++)
    begin
        assign pending_n[i] = ~irq_pending[i];
    end

    // Lower word: bit 0 reads one, bits 15-1 carry the first vectors
    always_comb
    begin
        lower_word = LOWER_PAD_ONES;
        for (int b = 0; b < LOWER_BITS; b++)
            lower_word[b + 1] = pending_n[b];
    end

    always_comb
    begin
        middle_word = 16'h0000;
        for (int b = 0; b < MIDDLE_BITS; b++)
            middle_word[b] = pending_n[LOWER_BITS + b];
    end

    // Upper word: bits above the last vector read one
    always_comb
    begin
        upper_word = UPPER_PAD_ONES;
        for (int b = 0; b < UPPER_BITS; b++)
            upper_word[b] = pending_n[UPPER_LSB + b];
    end

    always_comb
    begin
        read_word = 16'h0000;
        if (sel_control)
            read_word = control_word;
        else if (sel_lower)
            read_word = lower_word;
        else if (sel_middle)
            read_word = middle_word;
        else if (sel_upper)
            read_word = upper_word;
    end

    // Read data captured in the setup cycle, upper half zero
    always_comb
    begin
        next_prdata = prdata;
        if (setup_read)
            next_prdata = {16'h0000, read_word};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else
            prdata <= next_prdata;
    end

endmodule

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module testbench
    import iscr_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic        irq_request = 0, irq_fast = 0, core_reset_n = 0;
    logic        service_entry, core_irq, pready, pslverr, reset_vector_active;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0]  pstrb = 4'hf;
    logic [43:0] irq_pending = 44'h0;
    logic [1:0]  irq_level = 2'h0, dly = 2'h0, nested_level_required;
    logic [6:0]  irq_vector = 7'h0, fast_addr_low = 7'h0;
    logic [20:0] reset_vector = 21'h0a5a5a, irq_vector_addr = 21'h15a5a5, vector_bus;
    int          failures = 0, checks_done = 0;
    always #10 pclk = ~pclk;
    iscr_top uut (.*);
    iscr_core_model u_core (.pclk(pclk), .core_irq(core_irq), .delay(dly),
        .service_entry(service_entry));
    task final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task tmo(input int n);
        if (n >= 20)
        begin
            failures++;
            final_report();
        end
    endtask
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        tmo(n);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [9:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask
    task serve(input logic [1:0] lv, input logic [6:0] v, input logic f);
        int n;
        irq_level <= lv;
        irq_vector <= v;
        irq_fast <= f;
        fast_addr_low <= ~v;
        dly <= lv;
        irq_request <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (service_entry !== 1'b1 && n < 20);
        tmo(n);
        irq_request <= 1'b0;
        apb(1'b0, ADDR_CONTROL_STATUS, 32'h0);
        `CHK(r[14:6], {lv, f ? ~v : v})
        `CHK(nested_level_required, lv)
        repeat (2) @(posedge pclk);
    endtask
    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        final_report();
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(vector_bus, reset_vector)
        core_reset_n <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        `CHK(vector_bus, reset_vector)
        `CHK(reset_vector_active, 1'b1)
        @(posedge pclk);
        @(negedge pclk);
        `CHK(vector_bus, irq_vector_addr)
        `CHK(reset_vector_active, 1'b0)
        rd(ADDR_CONTROL_STATUS, 32'h0000001c);
        rd(ADDR_PENDING_UPPER, 32'h0000ffff);
        irq_pending <= 44'h800_8000_8001;
        rd(ADDR_PENDING_LOWER, 32'h0000fffd);
        rd(ADDR_PENDING_MIDDLE, 32'h0000fffe);
        rd(ADDR_PENDING_UPPER, 32'h0000effe);
        apb(1'b1, ADDR_CONTROL_STATUS, 32'hffffffff);
        rd(ADDR_CONTROL_STATUS, 32'h0000003c);
        irq_request <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(core_irq, 1'b0)
        apb(1'b1, ADDR_CONTROL_STATUS, 32'h0);
        apb(1'b0, ADDR_CONTROL_STATUS, 32'h0);
        `CHK(r[15], 1'b1)
        irq_request <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(core_irq, 1'b0)
        for (int i = 0; i < 4; i++)
            serve(i[1:0], 7'(i + 40), i[0]);
        apb(1'b0, 10'h3f0, 32'h0);
        `CHK({e, r}, 33'h100000000)
        final_report();
    end
endmodule
`default_nettype wire
